// [pkg/dbb_pkg.sv]
/*
  Shared constants and types for the DDR4 bank and burst addressing core.
  Assumes one command clock and a controller that obeys the command protocol.
*/
`default_nettype none

package dbb_pkg;

  // ----------------------------------------------------------------------
  // Decoded commands and power states
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    DBB_CMD_NOP  = 4'b0000,
    DBB_CMD_ACT  = 4'b0001,
    DBB_CMD_MRS  = 4'b0010,
    DBB_CMD_REF  = 4'b0011,
    DBB_CMD_PRE  = 4'b0100,
    DBB_CMD_PREA = 4'b0101,
    DBB_CMD_WR   = 4'b0110,
    DBB_CMD_RD   = 4'b0111,
    DBB_CMD_ZQS  = 4'b1000,
    DBB_CMD_ZQL  = 4'b1001
  } dbb_cmd_type;

  typedef enum logic [1:0] {
    DBB_PWR_ACTIVE = 2'b00,
    DBB_PWR_PDOWN  = 2'b01,
    DBB_PWR_SREF   = 2'b10
  } dbb_pwr_type;

  // ----------------------------------------------------------------------
  // Mode settings: register index is {bg[0], ba[1:0]}
  // ----------------------------------------------------------------------
  localparam logic [2:0] DBB_MR_BURST = 3'h0;
  localparam logic [2:0] DBB_MR_MPR = 3'h3;
  localparam logic [2:0] DBB_MR_CRC = 3'h4;
  localparam int DBB_BL_POS = 0;
  localparam int DBB_MPR_POS = 2;
  localparam int DBB_CRC_POS = 12;
  localparam logic [1:0] DBB_BL_FIX8 = 2'h0;
  localparam logic [1:0] DBB_BL_OTF = 2'h1;
  localparam logic [1:0] DBB_BL_FIX4 = 2'h2;
  localparam logic [1:0] DBB_BL_RESET = DBB_BL_FIX8;

  // ----------------------------------------------------------------------
  // Address bit positions and burst lengths in clocks (two beats each)
  // ----------------------------------------------------------------------
  localparam int DBB_AP_POS = 10;
  localparam int DBB_OTF_POS = 12;
  localparam logic [2:0] DBB_CLK_BL8 = 3'h4;
  localparam logic [2:0] DBB_CLK_BC4 = 3'h2;

endpackage : dbb_pkg

`default_nettype wire

// [logic/dbb_core.sv]
/*
  DDR4 bank, row and burst behaviour seen from the command pins, plus the
  write data FIFO. Assumes command, address and data arrive from controller
  logic on clk_sys; each clock carries a pair of data beats (rise, fall).
*/
`default_nettype none

// ------------------------------------------------------------------------
// Write data FIFO
// ------------------------------------------------------------------------
module dbb_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  // Full and empty come straight from the occupancy count; the count is one bit
  // wider than the pointers so that a full store is told apart from an empty one.
  assign in_ready = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign out_data = store[rd_ptr];

  // Storage needs no reset; only the pointers and the count carry control state.
  always_ff @(posedge clk_sys) begin
    if (push) begin
      store[wr_ptr] <= in_data;
    end
  end

  // Pointer and count update.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : dbb_fifo

// Summary of operation
// - x8 sixteen banks, x16 eight banks.
// - 8n prefetch, two words per clock.
// - Each BL8 access: four core clocks, eight beats.
// - Bursts start at column, eight or four.
// - ACT uses bank group, bank, row address.
// - A10 selects auto precharge after burst.
// - A12 chooses chop or full on fly.
// - Fixed and on-the-fly reads, writes, precharge.
// - Precharge, refresh, ZQ, MRS, self-refresh, power-down, MPR.
// - Write CRC follows data when enabled.
module dbb_core
  import dbb_pkg::*;
#(
  parameter bit X16 = 1'b0,
  parameter int ROW_BITS = 2,
  parameter int COL_HI_BITS = 2,
  parameter int FIFO_DEPTH = 32,
  parameter logic [15:0] MPR_PATTERN = 16'h55AA
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic cke,
  input wire logic cs_b,
  input wire logic act_b,
  input wire logic ras_b,
  input wire logic cas_b,
  input wire logic we_b,
  input wire logic [1:0] bg,
  input wire logic [1:0] ba,
  input wire logic [14:0] addr,
  input wire logic [2*(X16 ? 16 : 8)-1:0] wr_data,
  input wire logic wr_valid,
  output logic wr_ready,
  output logic [2*(X16 ? 16 : 8)-1:0] rd_data,
  output logic rd_valid,
  output logic burst_busy,
  output logic [15:0] bank_open,
  output logic [1:0] pwr_state,
  output logic cmd_err,
  output logic crc_err
);
  localparam int DQ_W = X16 ? 16 : 8;
  localparam int PW = 2 * DQ_W;
  localparam int MW = 4 + ROW_BITS + COL_HI_BITS + 2;

  // ----------------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------------
  function automatic dbb_cmd_type dbb_decode(input logic [4:0] pins, input logic a10);
    dbb_cmd_type c;
    c = DBB_CMD_NOP;
    if (!pins[4]) begin
      if (!pins[3]) begin
        c = DBB_CMD_ACT;
      end else begin
        case (pins[2:0])
          3'b000: c = DBB_CMD_MRS;
          3'b001: c = DBB_CMD_REF;
          3'b010: c = a10 ? DBB_CMD_PREA : DBB_CMD_PRE;
          3'b100: c = DBB_CMD_WR;
          3'b101: c = DBB_CMD_RD;
          3'b110: c = a10 ? DBB_CMD_ZQL : DBB_CMD_ZQS;
          default: c = DBB_CMD_NOP;
        endcase
      end
    end
    return c;
  endfunction : dbb_decode

  // x16 parts have one group select, so BG1 is ignored there.
  function automatic logic [3:0] dbb_bank(input logic [1:0] g, input logic [1:0] b);
    return X16 ? {1'b0, g[0], b} : {g, b};
  endfunction : dbb_bank

  dbb_cmd_type cmd;
  dbb_pwr_type pwr;
  logic [3:0] cbank;
  logic live;
  logic [1:0] bl_mode;
  logic crc_en;
  logic mpr_en;
  logic [ROW_BITS-1:0] open_row [16];
  logic busy;
  logic wr_mode;
  logic chop;
  logic auto_pre;
  logic crc_phase;
  logic [2:0] left;
  logic [1:0] pidx;
  logic [3:0] bbank;
  logic [COL_HI_BITS-1:0] bcol;
  logic [7:0] crc_acc;
  logic [PW-1:0] mem [2**MW];
  logic [PW-1:0] f_data;
  logic f_valid;
  logic f_ready;
  logic step;
  logic last_beat;
  logic done;
  logic next_chop;
  logic [MW-1:0] widx;

  assign cmd = dbb_decode({cs_b, act_b, ras_b, cas_b, we_b}, addr[DBB_AP_POS]);
  assign cbank = dbb_bank(bg, ba);
  assign live = cke && (pwr == DBB_PWR_ACTIVE);
  assign burst_busy = busy;
  assign pwr_state = pwr;

  // ----------------------------------------------------------------------
  // Write data path
  // ----------------------------------------------------------------------
  dbb_fifo #(
    .WIDTH(PW),
    .DEPTH(FIFO_DEPTH)
  ) u_wr_fifo (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .in_data(wr_data),
    .in_valid(wr_valid),
    .in_ready(wr_ready),
    .out_data(f_data),
    .out_valid(f_valid),
    .out_ready(f_ready)
  );

  // A write burst stalls on an empty FIFO instead of storing stale data.
  assign f_ready = busy & wr_mode;
  assign step = busy & (~wr_mode | f_valid);
  assign last_beat = step & ~crc_phase & (left == 3'h1);
  assign done = step & (crc_phase | (last_beat & ~(wr_mode & crc_en)));
  assign widx = {bbank, open_row[bbank], bcol, pidx};
  // Chop when fixed BC4, or on the fly with A12 low.
  assign next_chop = (bl_mode == DBB_BL_FIX4) ||
                     ((bl_mode == DBB_BL_OTF) && !addr[DBB_OTF_POS]);

  // ----------------------------------------------------------------------
  // Mode settings
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      bl_mode <= DBB_BL_RESET;
      crc_en <= 1'b0;
      mpr_en <= 1'b0;
    end else if (live && !busy && cmd == DBB_CMD_MRS) begin
      case ({bg[0], ba})
        DBB_MR_BURST: bl_mode <= addr[DBB_BL_POS +: 2];
        DBB_MR_MPR: mpr_en <= addr[DBB_MPR_POS];
        DBB_MR_CRC: crc_en <= addr[DBB_CRC_POS];
        default: bl_mode <= bl_mode;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Bank open state and rows
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      bank_open <= '0;
      for (int i = 0; i < 16; i++) begin
        open_row[i] <= '0;
      end
    end else begin
      if (live && !busy) begin
        case (cmd)
          DBB_CMD_ACT: begin
            bank_open[cbank] <= 1'b1;
            open_row[cbank] <= addr[ROW_BITS-1:0];
          end
          DBB_CMD_PRE: bank_open[cbank] <= 1'b0;
          DBB_CMD_PREA: bank_open <= '0;
          default: bank_open <= bank_open;
        endcase
      end
      if (done && auto_pre) begin
        bank_open[bbank] <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Burst engine: one clock moves one beat pair
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      busy <= 1'b0;
      wr_mode <= 1'b0;
      chop <= 1'b0;
      auto_pre <= 1'b0;
      crc_phase <= 1'b0;
      left <= '0;
      pidx <= '0;
      bbank <= '0;
      bcol <= '0;
      crc_acc <= '0;
    end else if (!busy) begin
      if (live && (cmd == DBB_CMD_RD || cmd == DBB_CMD_WR) && bank_open[cbank]) begin
        busy <= 1'b1;
        wr_mode <= (cmd == DBB_CMD_WR);
        chop <= next_chop;
        left <= next_chop ? DBB_CLK_BC4 : DBB_CLK_BL8;
        auto_pre <= addr[DBB_AP_POS];
        pidx <= addr[2:1];
        bbank <= cbank;
        bcol <= addr[3 +: COL_HI_BITS];
        crc_acc <= '0;
        crc_phase <= 1'b0;
      end
    end else if (step) begin
      if (crc_phase) begin
        crc_phase <= 1'b0;
      end else begin
        left <= left - 3'h1;
        // Chopped bursts wrap inside their half of the eight-beat block.
        pidx <= chop ? {pidx[1], ~pidx[0]} : pidx + 2'h1;
        crc_acc <= crc_acc ^ f_data[7:0] ^ f_data[PW-1 -: 8];
        if (last_beat && wr_mode && crc_en) begin
          crc_phase <= 1'b1;
        end
      end
      if (done) begin
        busy <= 1'b0;
      end
    end
  end

  // Array writes: a pair of n-bit beats lands per clock.
  always_ff @(posedge clk_sys) begin
    if (step && wr_mode && !crc_phase) begin
      mem[widx] <= f_data;
    end
  end

  // ----------------------------------------------------------------------
  // Read data and error flags
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rd_data <= '0;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= step & ~wr_mode;
      if (step && !wr_mode) begin
        rd_data <= mpr_en ? PW'(MPR_PATTERN) : mem[widx];
      end
    end
  end

  // The check value folds the low and the top byte of each beat pair; errors are one-clock pulses.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      crc_err <= 1'b0;
      cmd_err <= 1'b0;
    end else begin
      crc_err <= step & crc_phase & (f_data[7:0] != crc_acc);
      cmd_err <= live && (((cmd == DBB_CMD_RD || cmd == DBB_CMD_WR) &&
                 (busy || !bank_open[cbank])) ||
                 (cmd == DBB_CMD_REF && bank_open != '0) ||
                 (cmd == DBB_CMD_ACT && bank_open[cbank]));
    end
  end

  // ----------------------------------------------------------------------
  // Power state: idle CKE low with refresh and all banks closed enters self-refresh, else power-down
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pwr <= DBB_PWR_ACTIVE;
    end else begin
      case (pwr)
        DBB_PWR_ACTIVE: begin
          if (!cke && !busy) begin
            pwr <= (cmd == DBB_CMD_REF && bank_open == '0) ?
                   DBB_PWR_SREF : DBB_PWR_PDOWN;
          end
        end
        DBB_PWR_PDOWN: pwr <= cke ? DBB_PWR_ACTIVE : DBB_PWR_PDOWN;
        DBB_PWR_SREF: pwr <= cke ? DBB_PWR_ACTIVE : DBB_PWR_SREF;
        default: pwr <= DBB_PWR_ACTIVE;
      endcase
    end
  end

endmodule : dbb_core

`default_nettype wire

// [sim/dbb_core_asserts.sv]
/*
  Port checker for dbb_core: command acceptance, bursts, banks, power.
  Assumes it is bound to dbb_core and sees its ports only.
*/
`default_nettype none
module dbb_core_asserts
  import dbb_pkg::*;
#(
  parameter bit X16 = 1'b0
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic cke,
  input wire logic cs_b,
  input wire logic act_b,
  input wire logic ras_b,
  input wire logic cas_b,
  input wire logic we_b,
  input wire logic [1:0] bg,
  input wire logic [1:0] ba,
  input wire logic [14:0] addr,
  input wire logic burst_busy,
  input wire logic rd_valid,
  input wire logic [15:0] bank_open,
  input wire logic [1:0] pwr_state,
  input wire logic cmd_err
);
  // ----
  // Decode
  // ----
  // A command only counts when selected, clocked and awake.
  logic sel;
  logic go;
  logic rw;
  logic [3:0] idx;
  assign sel = !cs_b && cke && pwr_state == 2'h0;
  assign go = sel && !burst_busy;
  assign rw = act_b && ras_b && !cas_b;
  assign idx = X16 ? {1'b0, bg[0], ba} : {bg, ba};

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  act_opens_a: assert property (go && !act_b |=> bank_open[$past(idx)])
    else $error("bank not opened");
  act_twice_a: assert property (go && !act_b && bank_open[idx] |=> cmd_err)
    else $error("reopen not flagged");
  rd_closed_a: assert property (go && rw && !bank_open[idx] |=> cmd_err && !burst_busy)
    else $error("closed bank access taken");
  busy_cmd_a: assert property (sel && burst_busy && rw |=> cmd_err)
    else $error("access during burst not flagged");
  rd_beats_a: assert property (go && rw && we_b && bank_open[idx]
    |-> ##2 rd_valid [*2] ##[1:3] !rd_valid) else $error("read beat count wrong");
  busy_len_a: assert property ($rose(burst_busy) |-> burst_busy [*2] ##[1:40] !burst_busy)
    else $error("burst length wrong");
  pre_all_a: assert property (go && act_b && !ras_b && cas_b && !we_b && addr[DBB_AP_POS]
    |=> bank_open == 16'h0000) else $error("banks left open");
  cke_wake_a: assert property (cke && pwr_state != 2'h0 |=> pwr_state == 2'h0)
    else $error("no wake on clock enable");
endmodule : dbb_core_asserts

bind dbb_core dbb_core_asserts #(.X16(X16)) u_chk (.clk_sys, .rst_b, .cke, .cs_b, .act_b,
  .ras_b, .cas_b, .we_b, .bg, .ba, .addr, .burst_busy, .rd_valid, .bank_open, .pwr_state,
  .cmd_err);
`default_nettype wire

// [sim/dbb_ctrl_model.sv]
/*
  Controller model that drives commands and write words into the core.
  Assumes its tasks are called at a falling clock edge.
*/
`default_nettype none
module dbb_ctrl_model (
  input wire logic clk_sys,
  output logic cke,
  output logic cs_b,
  output logic act_b,
  output logic ras_b,
  output logic cas_b,
  output logic we_b,
  output logic [1:0] bg,
  output logic [1:0] ba,
  output logic [14:0] addr,
  output logic [15:0] wr_data,
  output logic wr_valid
);
  timeunit 1ns;
  timeprecision 1ps;

  // Start deselected and awake; the first accesses use the reset burst mode.
  initial begin
    cke = 1'b1;
    cs_b = 1'b1;
    {act_b, ras_b, cas_b, we_b} = 4'hF;
    {bg, ba} = 4'h0;
    addr = 15'h0000;
    wr_data = 16'h0000;
    wr_valid = 1'b0;
  end

  // One command for one clock; the task does not check that reads and writes go to open rows.
  // With more set the select stays low, so a command that follows at once does
  // not release and re-select the pin within one time step.
  task automatic cmd(input logic [3:0] c, input logic [3:0] b, input logic [14:0] a,
                     input bit more = 1'b0);
    {act_b, ras_b, cas_b, we_b} = c;
    {bg, ba} = b;
    addr = a;
    cs_b = 1'b0;
    @(negedge clk_sys);
    if (!more) begin
      cs_b = 1'b1;
      addr = ~a; // Deselected pins mean nothing, so the address is not held.
    end
  endtask : cmd

  // Self-refresh entry: the refresh is registered with the clock enable low.
  task automatic sref(input logic [3:0] c);
    cke = 1'b0;
    cmd(c, 4'h0, 15'h0000);
  endtask : sref

  // Offer one word; the caller has seen ready high before the next edge.
  task automatic push(input logic [15:0] d);
    wr_data = d;
    wr_valid = 1'b1;
    @(negedge clk_sys);
  endtask : push

  // Withdraw the offer and scramble the stale word.
  task automatic idle;
    wr_valid = 1'b0;
    wr_data = ~wr_data;
  endtask : idle

  // Change the clock enable for at least one clock.
  task automatic sleep(input logic v);
    cke = v;
    @(negedge clk_sys);
  endtask : sleep
endmodule : dbb_ctrl_model
`default_nettype wire

// [sim/ddr4_bank_burst_addressing_bench.sv]
/*
  Self-checking bench for dbb_core with an x8 build.
  Assumes the controller model and the bound port checker.
*/
`default_nettype none
module ddr4_bank_burst_addressing_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [3:0] C_ACT = 4'h7;
  localparam logic [3:0] C_MRS = 4'h8;
  localparam logic [3:0] C_REF = 4'h9;
  localparam logic [3:0] C_PRE = 4'hA;
  localparam logic [3:0] C_WR = 4'hC;
  localparam logic [3:0] C_RD = 4'hD;
  localparam logic [3:0] C_ZQ = 4'hE;
  localparam logic [15:0] MPR_WORD = 16'h3c5a;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic cke, cs_b, act_b, ras_b, cas_b, we_b, wr_valid, wr_ready, rd_valid;
  logic burst_busy, cmd_err, crc_err;
  logic [1:0] bg, ba, pwr_state;
  logic [14:0] addr;
  logic [15:0] wr_data, rd_data, bank_open;
  logic [15:0] got[$];
  logic saw_cmd, saw_crc;
  int err_total = 0;
  int num_checks = 0;

  dbb_ctrl_model u_m (.clk_sys, .cke, .cs_b, .act_b, .ras_b, .cas_b, .we_b, .bg, .ba,
    .addr, .wr_data, .wr_valid);
  dbb_core #(.X16(1'b0), .MPR_PATTERN(MPR_WORD)) u_dut (.clk_sys, .rst_b, .cke, .cs_b,
    .act_b, .ras_b, .cas_b,
    .we_b, .bg, .ba, .addr, .wr_data, .wr_valid, .wr_ready, .rd_data, .rd_valid,
    .burst_busy, .bank_open, .pwr_state, .cmd_err, .crc_err);

  // A 25 ns command clock.
  always #12.5 clk_sys = ~clk_sys;

  function automatic logic [15:0] w(input int k);
    return {8'(k + 64), 8'(k)};
  endfunction : w

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Record read pairs and error pulses over n clocks. Sampling starts with what
  // stands now, because the pulse for a command just given is already visible.
  task automatic watch(input int n);
    got = {};
    saw_cmd = 1'b0;
    saw_crc = 1'b0;
    repeat (n) begin
      if (rd_valid === 1'b1) got.push_back(rd_data);
      saw_cmd |= (cmd_err === 1'b1);
      saw_crc |= (crc_err === 1'b1);
      @(negedge clk_sys);
    end
  endtask : watch

  // Busy only rises a clock after a command, so always let one edge pass.
  task automatic wait_idle;
    do @(negedge clk_sys); while (burst_busy !== 1'b0);
  endtask : wait_idle

  // Read bank 0 and expect pairs from words 28 to 31 in burst order.
  task automatic rd_chk(input logic [14:0] a, input int n);
    int s;
    wait_idle();
    u_m.cmd(C_RD, 4'h0, a);
    watch(7);
    s = a[2:1];
    check(16'(got.size()), 16'(n));
    foreach (got[i]) check(got[i], w(28 + (n == 4 ? (s + i) % 4 : s ^ i)));
  endtask : rd_chk

  task automatic crc_wr(input logic [7:0] flip);
    logic [7:0] c;
    c = flip;
    for (int j = 0; j < 4; j++) begin
      u_m.push(w(j));
      c ^= 8'(j) ^ 8'(j + 64);
    end
    u_m.push({8'h00, c});
    u_m.idle();
    u_m.cmd(C_WR, 4'h0, 15'h0000);
    watch(8);
  endtask : crc_wr

  task automatic t_fill;
    int k;
    k = 0;
    check(bank_open, 16'h0000);
    while (wr_ready === 1'b1 && k < 40) begin
      u_m.push(w(k));
      k++;
    end
    u_m.idle();
    check(16'(k), 16'h0020);
    u_m.cmd(C_ACT, 4'h0, 15'h0000);
    repeat (8) begin
      wait_idle();
      u_m.cmd(C_WR, 4'h0, 15'h0000);
    end
    rd_chk(15'h0004, 4);
    $display("fill and burst test done");
  endtask : t_fill

  task automatic t_modes;
    u_m.cmd(C_MRS, 4'h0, 15'h0001);
    rd_chk(15'h0002, 2);
    rd_chk(15'h1002, 4);
    u_m.cmd(C_MRS, 4'h0, 15'h0002);
    rd_chk(15'h1000, 2);
    u_m.cmd(C_MRS, 4'h0, 15'h0000, 1'b1);
    u_m.cmd(C_MRS, 4'h3, 15'h0004, 1'b1);
    u_m.cmd(C_RD, 4'h0, 15'h0000);
    watch(7);
    check(got[0], MPR_WORD);
    check(16'(got.size()), 16'h0004);
    u_m.cmd(C_MRS, 4'h3, 15'h0000);
    $display("burst mode test done");
  endtask : t_modes

  task automatic t_bank;
    rd_chk(15'h0400, 4);
    check(bank_open, 16'h0000);
    u_m.cmd(C_ACT, 4'hE, 15'h0003, 1'b1);
    u_m.cmd(C_ACT, 4'hE, 15'h0003);
    watch(2);
    check(bank_open, 16'h4000);
    check(16'(saw_cmd), 16'h0001);
    u_m.cmd(C_ACT, 4'h5, 15'h0000, 1'b1);
    u_m.cmd(C_PRE, 4'hE, 15'h0000);
    watch(2);
    check(bank_open, 16'h0020);
    u_m.cmd(C_RD, 4'h9, 15'h0000);
    watch(7);
    check({15'h0000, saw_cmd}, 16'h0001);
    check(16'(got.size()), 16'h0000);
    u_m.cmd(C_ACT, 4'h0, 15'h0000, 1'b1);
    u_m.cmd(C_RD, 4'h0, 15'h0000, 1'b1);
    u_m.cmd(C_RD, 4'h0, 15'h0000);
    watch(7);
    check({saw_cmd, 15'(got.size())}, 16'h8004);
    u_m.cmd(C_ZQ, 4'h0, 15'h0000, 1'b1);
    u_m.cmd(C_ZQ, 4'h0, 15'h0400, 1'b1);
    u_m.cmd(C_REF, 4'h0, 15'h0000);
    watch(2);
    check({saw_cmd, bank_open[14:0]}, 16'h8021);
    u_m.cmd(C_PRE, 4'h0, 15'h0400);
    watch(2);
    check(bank_open, 16'h0000);
    $display("bank and error test done");
  endtask : t_bank

  task automatic t_crc;
    u_m.cmd(C_MRS, 4'h4, 15'h1000, 1'b1);
    u_m.cmd(C_ACT, 4'h0, 15'h0000);
    crc_wr(8'h00);
    check({15'h0000, saw_crc}, 16'h0000);
    crc_wr(8'h01);
    check({15'h0000, saw_crc}, 16'h0001);
    u_m.cmd(C_MRS, 4'h4, 15'h0000, 1'b1);
    u_m.cmd(C_PRE, 4'h0, 15'h0400);
    $display("write code test done");
  endtask : t_crc

  // Idle drop of clock enable gives power-down, with refresh on the same edge self-refresh.
  task automatic t_pwr;
    u_m.sleep(1'b0);
    watch(2);
    check(16'(pwr_state), 16'h0001);
    u_m.sleep(1'b1);
    watch(2);
    check(16'(pwr_state), 16'h0000);
    // Self-refresh needs the refresh and the low clock enable on one edge.
    u_m.sref(C_REF);
    watch(2);
    check(16'(pwr_state), 16'h0002);
    u_m.sleep(1'b1);
    watch(2);
    check(16'(pwr_state), 16'h0000);
    $display("power state test done");
  endtask : t_pwr

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : tally_and_finish

  // Hold reset five clocks, then run every scenario in turn.
  initial begin
    repeat (5) @(negedge clk_sys);
    rst_b = 1'b1;
    t_fill();
    t_modes();
    t_bank();
    t_crc();
    t_pwr();
    tally_and_finish();
  end

  // The scenarios need well under a thousand clocks; this allows 4000.
  initial begin
    #100us;
    err_total++;
    $display("ERROR %0t: watchdog expired", $time);
    tally_and_finish();
  end
endmodule : ddr4_bank_burst_addressing_bench
`default_nettype wire
